// ===== inc/ipm_pkg.sv
// constants and types for the idle/sleep power mode controller
// assumes one clock domain, mclk at 200 MHz, synchronous active-high reset
package ipm_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // cpu-ready delay and internal oscillator stabilization interval, in ns
  localparam int unsigned CPU_READY_NS = 100;
  localparam int unsigned INT_STABLE_NS = 1000;
  // least times round up to whole cycles
  localparam int unsigned CPU_READY_CYC = (CPU_READY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned INT_STABLE_CYC = (INT_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned WDT_W = 16;
  localparam int unsigned FREQ_W = 3;
  localparam int unsigned WDT_TIMEOUT_CYC = 50000;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;

  // control field positions
  localparam int unsigned CTRL_IDLE_SEL = 0;
  localparam int unsigned CTRL_CS_LO = 1;
  localparam int unsigned CTRL_CS_HI = 2;
  localparam int unsigned CTRL_FREQ_LSB = 4;
  localparam int unsigned CTRL_INT_SRC = 7;
  localparam int unsigned CTRL_T1_EN = 8;
  // config field positions
  localparam int unsigned CFG_WDT_EN = 0;
  localparam int unsigned CFG_FSCM_EN = 1;
  localparam int unsigned CFG_TWO_SPEED = 2;
  // status field positions
  localparam int unsigned ST_PRI_RDY = 0;
  localparam int unsigned ST_INT_STB = 1;
  localparam int unsigned ST_T1_RUN = 2;
  localparam int unsigned ST_MODE_LSB = 4;

  // clock_select encodings
  localparam logic [1:0] CS_PRIMARY = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;

  typedef enum logic [2:0] {
    ST_RESET_HOLD,
    ST_RUN,
    ST_IDLE,
    ST_SLEEP,
    ST_WAKE_WAIT,
    ST_WAKE_DELAY
  } ipm_state_t;
endpackage : ipm_pkg

// ===== verilog/ipm_ctrl.sv
// idle/sleep power mode controller: cpu and peripheral clock gating, wake sequencing
// assumes cpu strobes sleep/wdt-clear for one cycle and oscillators report ready levels
//
// Function
// [RULE1] idle sleep gates cpu, keeps peripherals
// [RULE2] idle keeps slow rc and timer1 running; slow rc on for watchdog, fail-safe, internal source or reset hold
// [RULE3] idle exit only interrupt, watchdog, reset
// [RULE4] wake waits cpu-ready delay, same source
// [RULE5] watchdog in idle/sleep wakes, no reset
// [RULE6] primary idle keeps primary clock, flag
// [RULE7] timer1 select stops primary, sets t1 flag
// [RULE8] sleep ignored if timer1 disabled
// [RULE9] peripheral clock waits timer1 start
// [RULE10] upper select stops primary, clears flag
// [RULE11] internal output enabled, flag after stabilization
// [RULE12] stable flag kept; disabled when unselected
// [RULE13] internal_idle_mode wake stays on internal mux
// [RULE14] enabled interrupt flag starts exit
// [RULE15] branch to vector if global enable
// [RULE16] resume first cycle after delay
// [RULE17] watchdog in run mode resets
// [RULE18] watchdog cleared on listed events
// [RULE19] reset exit waits primary ready
// [RULE20] two-speed start runs on internal mux
// [RULE21] full sleep stops clocks, clears flags
// [RULE22] delays are parameterized cycle counts
`timescale 1ns/1ps
module ipm_ctrl #(
  parameter int unsigned CPU_READY_CYCLES = ipm_pkg::CPU_READY_CYC,
  parameter int unsigned INT_STABLE_CYCLES = ipm_pkg::INT_STABLE_CYC,
  parameter int unsigned WDT_TIMEOUT = ipm_pkg::WDT_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic irq_pending,
  input wire logic global_irq_enable,
  input wire logic primary_osc_ready,
  input wire logic timer1_osc_running,
  input wire logic primary_is_internal,
  input wire logic clock_lost,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic [1:0] periph_clk_src,
  output logic primary_osc_en,
  output logic timer1_osc_en,
  output logic fast_internal_osc_en,
  output logic slow_internal_rc_en,
  output logic cpu_resume,
  output logic irq_vector_branch,
  output logic watchdog_reset,
  output logic cpu_in_reset
);
  import ipm_pkg::*;

  localparam logic [1:0] SRC_PRIMARY = 2'h0;
  localparam logic [1:0] SRC_TIMER1 = 2'h1;
  localparam logic [1:0] SRC_INTERNAL = 2'h2;

  logic idle_select_q;
  logic [1:0] clock_select_q;
  logic [FREQ_W-1:0] internal_freq_select_q;
  logic internal_source_select_q;
  logic timer1_osc_enable_q;
  logic wdt_en_q, fscm_en_q, two_speed_q;
  logic primary_ready_flag_q, internal_stable_flag_q, timer1_clock_running_flag_q;
  ipm_state_t state_q;
  logic [CNT_W-1:0] delay_q;
  logic [CNT_W-1:0] stab_q;
  logic [WDT_W-1:0] wdt_q;
  logic irq_wake_q;
  logic [1:0] src_q;
  logic primary_on_q;

  logic apb_wr, apb_rd, freq_write, wdt_timeout, wake_evt, int_out_req, sleep_ok;
  logic [1:0] req_src;
  logic clock_select_upper, clock_select_lower;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign clock_select_upper = clock_select_q[1];
  assign clock_select_lower = clock_select_q[0];
  assign freq_write = apb_wr && paddr == REG_CTRL &&
                      pwdata[CTRL_FREQ_LSB +: FREQ_W] != internal_freq_select_q;
  assign wdt_timeout = wdt_en_q && wdt_q >= WDT_W'(WDT_TIMEOUT - 1);
  // [RULE11] internal output request
  assign int_out_req = internal_freq_select_q != '0 || internal_source_select_q;
  // [RULE10] upper bit wins, lower ignored
  assign req_src = clock_select_upper ? SRC_INTERNAL :
                   (clock_select_lower ? SRC_TIMER1 : SRC_PRIMARY);
  // [RULE8] timer1 request needs enabled oscillator
  assign sleep_ok = !(idle_select_q && req_src == SRC_TIMER1 && !timer1_osc_enable_q);
  // [RULE3] only these wake the cpu
  // [RULE14] enabled pending flag starts exit
  assign wake_evt = irq_pending || wdt_timeout;

  always_ff @(posedge mclk) begin
    if (rst) begin
      idle_select_q <= 1'b0;
      clock_select_q <= CS_PRIMARY;
      internal_freq_select_q <= '0;
      internal_source_select_q <= 1'b0;
      timer1_osc_enable_q <= 1'b0;
      wdt_en_q <= 1'b0;
      fscm_en_q <= 1'b0;
      two_speed_q <= 1'b0;
    end else if (apb_wr && paddr == REG_CTRL) begin
      idle_select_q <= pwdata[CTRL_IDLE_SEL];
      clock_select_q <= {pwdata[CTRL_CS_HI], pwdata[CTRL_CS_LO]};
      internal_freq_select_q <= pwdata[CTRL_FREQ_LSB +: FREQ_W];
      internal_source_select_q <= pwdata[CTRL_INT_SRC];
      timer1_osc_enable_q <= pwdata[CTRL_T1_EN];
    end else if (apb_wr && paddr == REG_CFG) begin
      wdt_en_q <= pwdata[CFG_WDT_EN];
      fscm_en_q <= pwdata[CFG_FSCM_EN];
      two_speed_q <= pwdata[CFG_TWO_SPEED];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != REG_CTRL && paddr != REG_STATUS && paddr != REG_CFG;
      prdata <= '0;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          REG_CTRL: begin
            prdata[CTRL_IDLE_SEL] <= idle_select_q;
            prdata[CTRL_CS_LO] <= clock_select_q[0];
            prdata[CTRL_CS_HI] <= clock_select_q[1];
            prdata[CTRL_FREQ_LSB +: FREQ_W] <= internal_freq_select_q;
            prdata[CTRL_INT_SRC] <= internal_source_select_q;
            prdata[CTRL_T1_EN] <= timer1_osc_enable_q;
          end
          REG_STATUS: begin
            prdata[ST_PRI_RDY] <= primary_ready_flag_q;
            prdata[ST_INT_STB] <= internal_stable_flag_q;
            prdata[ST_T1_RUN] <= timer1_clock_running_flag_q;
            prdata[ST_MODE_LSB +: 3] <= state_q;
          end
          REG_CFG: begin
            prdata[CFG_WDT_EN] <= wdt_en_q;
            prdata[CFG_FSCM_EN] <= fscm_en_q;
            prdata[CFG_TWO_SPEED] <= two_speed_q;
          end
          default: prdata <= '0;
        endcase
      end
    end
  end

  // mode sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_RESET_HOLD;
      delay_q <= '0;
      irq_wake_q <= 1'b0;
      src_q <= SRC_PRIMARY;
      primary_on_q <= 1'b1;
      cpu_resume <= 1'b0;
      irq_vector_branch <= 1'b0;
      watchdog_reset <= 1'b0;
    end else begin
      cpu_resume <= 1'b0;
      irq_vector_branch <= 1'b0;
      watchdog_reset <= 1'b0;
      case (state_q)
        ST_RESET_HOLD: begin
          primary_on_q <= 1'b1;
          // [RULE20] two-speed start on internal mux
          if (two_speed_q || fscm_en_q) begin
            src_q <= SRC_INTERNAL;
            state_q <= ST_RUN;
          // [RULE19] held by start-up timer
          end else if (primary_osc_ready) begin
            src_q <= SRC_PRIMARY;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (src_q == SRC_INTERNAL && primary_on_q && primary_osc_ready && req_src == SRC_PRIMARY) begin
            src_q <= SRC_PRIMARY;
          end
          // [RULE17] run-mode timeout resets
          if (wdt_timeout) begin
            watchdog_reset <= 1'b1;
            state_q <= ST_RESET_HOLD;
          end else if (sleep_instr && sleep_ok) begin
            // [RULE1] cpu stops, peripherals take selected source
            if (idle_select_q) begin
              state_q <= ST_IDLE;
              src_q <= req_src;
              // [RULE6] primary idle keeps primary running
              // [RULE7] timer1 idle stops primary
              primary_on_q <= req_src == SRC_PRIMARY;
            end else begin
              // [RULE21] full sleep stops oscillator
              state_q <= ST_SLEEP;
              primary_on_q <= 1'b0;
            end
          end
        end
        ST_IDLE, ST_SLEEP: begin
          if (wake_evt) begin
            irq_wake_q <= irq_pending;
            delay_q <= CNT_W'(CPU_READY_CYCLES);
            // [RULE5] wake to run mode of current select
            src_q <= req_src;
            primary_on_q <= req_src == SRC_PRIMARY;
            state_q <= (state_q == ST_SLEEP && req_src == SRC_PRIMARY && !(two_speed_q || fscm_en_q)) ?
                       ST_WAKE_WAIT : ST_WAKE_DELAY;
            // [RULE20] sleep wake on internal mux first
            if (state_q == ST_SLEEP && req_src == SRC_PRIMARY && (two_speed_q || fscm_en_q)) begin
              src_q <= SRC_INTERNAL;
            end
          end
        end
        ST_WAKE_WAIT: begin
          if (primary_osc_ready) begin
            state_q <= ST_WAKE_DELAY;
          end
        end
        ST_WAKE_DELAY: begin
          // [RULE4] cpu-ready delay before execution
          if (delay_q > CNT_W'(1)) begin
            delay_q <= delay_q - CNT_W'(1);
          end else begin
            // [RULE16] resume right after the delay
            state_q <= ST_RUN;
            cpu_resume <= 1'b1;
            // [RULE15] vector only with global enable
            irq_vector_branch <= irq_wake_q && global_irq_enable;
          end
        end
        default: state_q <= ST_RESET_HOLD;
      endcase
    end
  end

  // [RULE18] watchdog clear events
  always_ff @(posedge mclk) begin
    if (rst) begin
      wdt_q <= '0;
    end else if (sleep_instr || watchdog_clear_instr || (fscm_en_q && clock_lost) ||
                 (freq_write && src_q == SRC_INTERNAL) || wdt_timeout || !wdt_en_q) begin
      wdt_q <= '0;
    end else begin
      wdt_q <= wdt_q + WDT_W'(1);
    end
  end

  // [RULE11] stabilization count for internal output
  always_ff @(posedge mclk) begin
    if (rst) begin
      stab_q <= '0;
    end else if (!int_out_req) begin
      stab_q <= '0;
    end else if (stab_q < CNT_W'(INT_STABLE_CYCLES)) begin
      stab_q <= stab_q + CNT_W'(1);
    end
  end

  // clock-source status flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      primary_ready_flag_q <= 1'b0;
      internal_stable_flag_q <= 1'b0;
      timer1_clock_running_flag_q <= 1'b0;
    end else if (state_q == ST_SLEEP) begin
      // [RULE21] all flags clear in sleep
      primary_ready_flag_q <= 1'b0;
      internal_stable_flag_q <= 1'b0;
      timer1_clock_running_flag_q <= 1'b0;
    end else if (state_q != ST_IDLE || src_q != SRC_PRIMARY) begin
      // [RULE7] timer1 flag, primary cleared
      // [RULE19] primary flag when primary clocks
      primary_ready_flag_q <= src_q == SRC_PRIMARY && primary_on_q && primary_osc_ready;
      timer1_clock_running_flag_q <= src_q == SRC_TIMER1 && timer1_osc_running;
      // [RULE12] flag held while stable, clear if off
      internal_stable_flag_q <= int_out_req && stab_q >= CNT_W'(INT_STABLE_CYCLES) &&
                                (src_q == SRC_INTERNAL || primary_is_internal);
    end
  end

  // clock enables and oscillator controls
  always_ff @(posedge mclk) begin
    if (rst) begin
      cpu_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      periph_clk_src <= SRC_PRIMARY;
      primary_osc_en <= 1'b1;
      timer1_osc_en <= 1'b0;
      fast_internal_osc_en <= 1'b0;
      slow_internal_rc_en <= 1'b1;
      cpu_in_reset <= 1'b1;
    end else begin
      cpu_in_reset <= state_q == ST_RESET_HOLD && !(two_speed_q || fscm_en_q);
      cpu_clk_en <= state_q == ST_RUN;
      // [RULE9] peripherals wait for timer1 start
      // [RULE13] internal mux keeps clocking on wake
      periph_clk_en <= (state_q == ST_RUN || state_q == ST_IDLE || state_q == ST_WAKE_DELAY) &&
                       !(src_q == SRC_TIMER1 && !timer1_osc_running);
      periph_clk_src <= src_q;
      primary_osc_en <= primary_on_q;
      // [RULE2] timer1 keeps running when enabled
      timer1_osc_en <= timer1_osc_enable_q;
      // [RULE11] fast internal output enable
      fast_internal_osc_en <= int_out_req;
      // [RULE2] slow rc kept for watchdog
      // [RULE13] also for fail-safe monitor
      slow_internal_rc_en <= wdt_en_q || fscm_en_q || src_q == SRC_INTERNAL || state_q == ST_RESET_HOLD;
    end
  end
endmodule : ipm_ctrl

// ===== verification/ipm_ctrl_chk.sv
// port checker for ipm_ctrl, bound into every instance
// assumes primary_is_internal low and two-speed start-up off
`timescale 1ns/1ps
module ipm_ctrl_chk #(
  parameter int unsigned CPU_READY_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_pending,
  input wire logic global_irq_enable,
  input wire logic primary_osc_ready,
  input wire logic timer1_osc_running,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic [1:0] periph_clk_src,
  input wire logic primary_osc_en,
  input wire logic cpu_resume,
  input wire logic irq_vector_branch,
  input wire logic watchdog_reset,
  input wire logic cpu_in_reset
);
  localparam int RD = CPU_READY_CYCLES;
  localparam int RD1 = CPU_READY_CYCLES + 1;
  wire logic idle = periph_clk_en && !cpu_clk_en && !cpu_in_reset;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("apb access cycle without ready");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("slave error outside ready");
  AST_WAKE_DELAY: assert property (idle && $rose(irq_pending) |-> ##[RD:RD1] cpu_resume)
    else $error("wake did not resume after ready delay");
  AST_RESUME_CPU: assert property (cpu_resume |=> cpu_clk_en)
    else $error("cpu clock not running after resume");
  AST_CPU_CAUSE: assert property ($rose(cpu_clk_en) |->
    $past(cpu_resume) || $past(cpu_in_reset) || $past(cpu_in_reset, 2))
    else $error("cpu restarted without wake or reset");
  AST_BRANCH: assert property (irq_vector_branch |-> cpu_resume && global_irq_enable)
    else $error("vector branch without resume or global enable");
  AST_WDT_RUN: assert property (watchdog_reset |-> $past(cpu_clk_en))
    else $error("watchdog reset while not executing");
  AST_PRIMARY_IDLE_MODE: assert property (idle && periph_clk_src == 2'h0 |-> primary_osc_en && primary_osc_ready)
    else $error("primary idle without running primary clock");
  AST_T1_WAIT: assert property (periph_clk_en && periph_clk_src == 2'h1 |-> timer1_osc_running)
    else $error("peripherals clocked before timer1 started");
  AST_ALT_IDLE: assert property (idle && periph_clk_src != 2'h0 ##1 idle |-> !primary_osc_en)
    else $error("primary oscillator left on in alternate idle");
  AST_RESET_EXIT: assert property (cpu_in_reset && primary_osc_ready |-> ##[1:16] !cpu_in_reset)
    else $error("reset hold kept after primary ready");
  CVR_IDLE_WAKE: cover property (idle && $rose(irq_pending));
  CVR_BRANCH: cover property (irq_vector_branch);
  CVR_WDT_RESET: cover property (watchdog_reset);
endmodule : ipm_ctrl_chk

bind ipm_ctrl ipm_ctrl_chk #(.CPU_READY_CYCLES(CPU_READY_CYCLES)) u_chk (.mclk, .rst, .psel, .penable, .pready,
  .pslverr, .irq_pending, .global_irq_enable, .primary_osc_ready, .timer1_osc_running, .cpu_clk_en,
  .periph_clk_en, .periph_clk_src, .primary_osc_en, .cpu_resume, .irq_vector_branch, .watchdog_reset, .cpu_in_reset);

// ===== verification/ipm_osc_model.sv
// oscillator sources seen by ipm_ctrl: primary and timer1
// assumes enables come from ipm_ctrl; slow stretches timer1 start-up
`timescale 1ns/1ps
module ipm_osc_model #(
  parameter int START = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic primary_osc_en,
  input wire logic timer1_osc_en,
  output logic primary_osc_ready,
  output logic timer1_osc_running
);
  int pri_q;
  int t1_q;
  // a stopped oscillator reports not ready after the next clock edge, never its old level
  always_ff @(posedge mclk) begin
    pri_q <= (rst || !primary_osc_en) ? 0 : pri_q + 32'(pri_q < 64);
    t1_q <= (rst || !timer1_osc_en) ? 0 : t1_q + 32'(t1_q < 64);
  end
  assign primary_osc_ready = pri_q >= START;
  assign timer1_osc_running = t1_q >= (slow ? 4 * START : START);
endmodule : ipm_osc_model

// ===== verification/tb_ipm_ctrl.sv
// self-checking bench for ipm_ctrl with the oscillator model
// assumes shortened delay parameters and the apb map of ipm_pkg
`timescale 1ns/1ps
module tb_ipm_ctrl;
  import ipm_pkg::*;
  localparam int RD = 2;
  localparam int IS = 4;
  localparam int WT = 64;
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sleep_instr = 0;
  logic irq_pending = 0, gie = 0, slow = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] periph_clk_src;
  logic pready, pslverr, cpu_clk_en, periph_clk_en, primary_osc_en, timer1_osc_en, fast_internal_osc_en;
  logic slow_rc, cpu_resume, irq_vector_branch, watchdog_reset, cpu_in_reset, primary_osc_ready, timer1_osc_running;
  int n_errors = 0;
  int num_checks = 0;

  ipm_ctrl #(.CPU_READY_CYCLES(RD), .INT_STABLE_CYCLES(IS), .WDT_TIMEOUT(WT)) uut (.mclk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr, .watchdog_clear_instr(1'b0), .irq_pending,
    .global_irq_enable(gie), .primary_osc_ready, .timer1_osc_running, .primary_is_internal(1'b0), .clock_lost(1'b0),
    .cpu_clk_en, .periph_clk_en, .periph_clk_src, .primary_osc_en, .timer1_osc_en, .fast_internal_osc_en,
    .slow_internal_rc_en(slow_rc), .cpu_resume, .irq_vector_branch, .watchdog_reset, .cpu_in_reset);
  ipm_osc_model osc (.mclk, .rst, .slow, .primary_osc_en, .timer1_osc_en, .primary_osc_ready, .timer1_osc_running);

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  task automatic wait_for(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v) begin
      @(negedge mclk);
      k++;
      if (k > lim) begin
        chk(s, v);
        end_sim();
      end
    end
  endtask : wait_for

  // request held until pready is sampled high; answer taken from the settled value before that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic rdy;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(negedge mclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
      k++;
      if (!rdy && k > 20) begin
        chk(rdy, 1'b1);
        end_sim();
      end
      @(posedge mclk);
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic go_sleep(input logic [31:0] ctrl);
    apb(1'b1, REG_CTRL, ctrl);
    @(posedge mclk);
    sleep_instr <= 1'b1;
    @(posedge mclk);
    sleep_instr <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask : go_sleep

  task automatic wake_irq(input logic g, input logic timed);
    int n;
    @(posedge mclk);
    gie <= g;
    irq_pending <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (cpu_resume !== 1'b1 && n < 200);
    chk(irq_vector_branch, g);
    // irq seen one edge after it is driven, then RD edges of delay, then the pulse shows
    if (timed) chk(n, RD + 2);
    @(negedge mclk);
    chk(cpu_clk_en, 1'b1);
    @(posedge mclk);
    irq_pending <= 1'b0;
  endtask : wake_irq

  task automatic t_reset();
    wait_for(cpu_in_reset, 1'b0, 100);
    chk(cpu_clk_en, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[ST_PRI_RDY], 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk({err, rd}, 33'h100000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_primary_idle_mode();
    go_sleep(32'h001);
    chk({cpu_clk_en, periph_clk_en, periph_clk_src}, 4'b0100);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0], 3'b001);
    wake_irq(1'b1, 1'b1);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd[8:0], 9'h001);
    $display("test primary idle done");
  endtask : t_primary_idle_mode

  task automatic t_sleep();
    go_sleep(32'h000);
    chk({cpu_clk_en, periph_clk_en}, 2'b00);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0], 3'b000);
    wake_irq(1'b0, 1'b0);
    $display("test full sleep done");
  endtask : t_sleep

  task automatic t_secondary_idle_mode();
    go_sleep(32'h003);
    chk(cpu_clk_en, 1'b1);
    slow = 1'b1;
    go_sleep(32'h103);
    chk(periph_clk_en, 1'b0);
    wait_for(periph_clk_en, 1'b1, 100);
    chk({periph_clk_src, primary_osc_en}, 3'b010);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0], 3'b100);
    wake_irq(1'b0, 1'b1);
    chk(periph_clk_src, 2'h1);
    slow = 1'b0;
    $display("test timer1 idle done");
  endtask : t_secondary_idle_mode

  task automatic t_internal_idle_mode();
    go_sleep(32'h137);
    chk({periph_clk_src, primary_osc_en, fast_internal_osc_en}, 4'b1001);
    repeat (IS + 2) @(negedge mclk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[1:0], 2'b10);
    wake_irq(1'b1, 1'b1);
    chk(periph_clk_src, 2'h2);
    $display("test internal idle done");
  endtask : t_internal_idle_mode

  task automatic t_wdt();
    apb(1'b1, REG_CFG, 32'h1);
    go_sleep(32'h137);
    chk(slow_rc, 1'b1);
    wait_for(cpu_resume, 1'b1, WT + 50);
    chk({cpu_in_reset, watchdog_reset}, 2'b00);
    wait_for(watchdog_reset, 1'b1, WT + 50);
    chk(cpu_clk_en, 1'b1);
    $display("test watchdog done");
  endtask : t_wdt

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk(cpu_in_reset, 1'b1);
    t_reset();
    t_primary_idle_mode();
    t_sleep();
    t_secondary_idle_mode();
    t_internal_idle_mode();
    t_wdt();
    end_sim();
  end
endmodule : tb_ipm_ctrl
